// ===== rtl/sem_pkg.sv
package sem_pkg;

    // ----------------------------------------
    // register offsets (byte addresses on the serial register space)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CORE_STATUS = 8'h1a;
    localparam logic [7:0] ADDR_TEMPERATURE_STATUS = 8'h1b;
    localparam logic [7:0] ADDR_SRC1_METER_LOW = 8'h1c;
    localparam logic [7:0] ADDR_SRC1_METER_MID = 8'h1d;
    localparam logic [7:0] ADDR_SRC1_METER_HIGH = 8'h1e;
    localparam logic [7:0] ADDR_SRC2_METER_LOW = 8'h1f;
    localparam logic [7:0] ADDR_SRC2_METER_MID = 8'h20;
    localparam logic [7:0] ADDR_SRC2_METER_HIGH = 8'h21;
    localparam logic [7:0] ADDR_OUTPUT_METER_LOW = 8'h22;
    localparam logic [7:0] ADDR_OUTPUT_METER_MID = 8'h23;
    localparam logic [7:0] ADDR_OUTPUT_METER_HIGH = 8'h24;
    localparam logic [7:0] ADDR_CHARGER_DUTY_LOW = 8'h25;
    localparam logic [7:0] ADDR_CHARGER_DUTY_HIGH = 8'h26;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [23:0] METER_RESET = 24'h000000;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ----------------------------------------
    // field positions of the core status register
    // ----------------------------------------
    localparam int CORE_DEPLETED_BIT = 0;
    localparam int CORE_CHARGE_OK_BIT = 1;
    localparam int CORE_OVER_LIMIT_BIT = 2;
    localparam int CORE_FIRST_WEAK_BIT = 3;
    localparam int CORE_SECOND_WEAK_BIT = 4;
    localparam int CORE_CHARGER_BIT = 5;

    // ----------------------------------------
    // field positions of the temperature status register
    // ----------------------------------------
    localparam int TEMP_CHG_CHILLY_BIT = 0;
    localparam int TEMP_CHG_WARM_BIT = 1;
    localparam int TEMP_DIS_CHILLY_BIT = 2;
    localparam int TEMP_DIS_WARM_BIT = 3;

    // ----------------------------------------
    // metering word layout
    // ----------------------------------------
    localparam int METER_W = 24;
    localparam int PLAIN_COUNT_W = 23;
    localparam int MANTISSA_W = 19;
    localparam int EXPONENT_W = 5;
    localparam int DUTY_W = 16;
    localparam int CONVERTER_N = 3;

    // ----------------------------------------
    // timing: window slots and depletion qualification
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SLOT_TIME_NS = 1_812_500;
    localparam int SLOT_CYC = SLOT_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int SLOTS_SHORT_WINDOW = 64;
    localparam int SLOTS_LONG_WINDOW = 128;
    localparam int DEPLETION_QUALIFY_TIME_US = 1000;
    localparam int DEPLETION_QUALIFY_CYC = DEPLETION_QUALIFY_TIME_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------
    // metering modes
    // ----------------------------------------
    typedef enum logic {
        SEM_PULSE_COUNTER = 1'b0,
        SEM_POWER_METER = 1'b1
    } sem_mode_t;

    // ----------------------------------------
    // qualified comparator levels from the analog front end
    // ----------------------------------------
    typedef struct packed {
        logic aux_charger_present;
        logic second_input_weak;
        logic first_input_weak;
        logic storage_over_limit;
        logic storage_charge_ok;
        logic storage_at_depletion;
        logic discharge_too_warm;
        logic discharge_too_chilly;
        logic charge_too_warm;
        logic charge_too_chilly;
    } sem_levels_t;

    // ----------------------------------------
    // one converter's pulse report
    // ----------------------------------------
    typedef struct packed {
        logic pulse;
        logic [7:0] energy;
    } sem_pulse_t;

endpackage : sem_pkg

// ===== rtl/sem_meter_readout.sv
`timescale 1ns/1ps
module sem_meter_readout #(
    parameter int SETTING_W = 3, // width of the window sum setting
    parameter int SLOT_CYCLES = sem_pkg::SLOT_CYC, // clocks per duty slot
    parameter int QUALIFY_CYCLES = sem_pkg::DEPLETION_QUALIFY_CYC, // depletion hold time in clocks
    parameter int ACC_W = 40 // raw accumulator width
) (
    input wire logic clk_in, // 10 MHz clock
    input wire logic sys_rst_in, // asynchronous reset, active high
    input wire sem_pkg::sem_levels_t levels_in, // comparator levels
    input wire sem_pkg::sem_pulse_t [sem_pkg::CONVERTER_N-1:0] conv_in, // 0 src1, 1 src2, 2 output
    input wire logic aux_charging_in, // charger actively charging storage
    input wire sem_pkg::sem_mode_t mode_in, // metering mode
    input wire logic long_window_in, // 1 selects the 232 ms window
    input wire logic [SETTING_W-1:0] window_sum_setting_in, // accumulated windows minus one
    input wire logic rd_en_in, // register read strobe
    input wire logic [7:0] rd_addr_in, // register offset
    output logic [7:0] rd_data_out, // read data
    output logic rd_valid_out, // read data valid pulse
    output logic window_done_out // new metering words latched pulse
);
    import sem_pkg::*;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (SETTING_W < 1 || SETTING_W > 8) begin : g_bad_setting
        $error("window sum setting width out of range");
    end
    if (ACC_W < 24 || ACC_W > 50 || SLOT_CYCLES < 1 || QUALIFY_CYCLES < 1) begin : g_bad_sizes
        $error("accumulator or timing parameter out of range");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [7:0] core_status_ff; // live core status
    logic [7:0] temperature_status_ff; // live temperature status
    logic [31:0] depl_cnt_ff; // cycles spent at/below depletion limit
    logic depleted_ff; // qualified depletion
    logic [31:0] slot_cnt_ff; // divider toward one slot
    logic slot_tick_ff; // one-cycle slot enable
    logic [7:0] slots_in_window_ff; // slots elapsed in current window
    logic window_end; // last slot of window
    logic [SETTING_W-1:0] windows_done_ff; // windows summed so far
    logic span_end; // last window of the summed span
    logic [ACC_W-1:0] acc_ff [CONVERTER_N]; // raw sum per converter
    logic [METER_W-1:0] meter_ff [CONVERTER_N]; // latched metering words
    logic [DUTY_W:0] duty_acc_ff; // charging slots, one spare bit
    logic [DUTY_W-1:0] duty_ff; // latched duty counter
    logic window_done_ff; // latched strobe
    logic [7:0] nxt_rd_data; // selected read byte
    logic [7:0] slots_per_window; // 64 or 128

    // ----------------------------------------
    // encode raw sum into the 24-bit layout
    // ----------------------------------------
    function automatic logic [METER_W-1:0] encode(input logic [ACC_W-1:0] raw, input logic plain);
        logic [4:0] expo;
        logic [ACC_W-1:0] shifted;
        expo = 5'h00;
        shifted = raw;
        if (plain) begin
            // plain count, saturating at 23 bits
            if (raw >= (ACC_W'(1) << PLAIN_COUNT_W)) begin
                encode = {1'b0, {PLAIN_COUNT_W{1'b1}}};
            end else begin
                encode = {1'b0, raw[PLAIN_COUNT_W-1:0]};
            end
        end else begin
            // smallest exponent that fits the mantissa
            for (int i = 0; i < ACC_W - MANTISSA_W + 1; i++) begin
                if ((raw >> expo) >= (ACC_W'(1) << MANTISSA_W)) begin
                    expo = expo + 5'h01;
                end
            end
            shifted = raw >> expo;
            encode = {expo, shifted[MANTISSA_W-1:0]};
        end
    endfunction : encode

    // ----------------------------------------
    // status registers mirror the levels; core bit 0 is the qualified depletion
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            core_status_ff <= STATUS_RESET;
        end else begin
            // reserved bits stay zero
            core_status_ff <= STATUS_RESET;
            core_status_ff[CORE_CHARGER_BIT] <= levels_in.aux_charger_present;
            core_status_ff[CORE_SECOND_WEAK_BIT] <= levels_in.second_input_weak;
            core_status_ff[CORE_FIRST_WEAK_BIT] <= levels_in.first_input_weak;
            core_status_ff[CORE_OVER_LIMIT_BIT] <= levels_in.storage_over_limit;
            core_status_ff[CORE_CHARGE_OK_BIT] <= levels_in.storage_charge_ok;
            core_status_ff[CORE_DEPLETED_BIT] <= depleted_ff;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            temperature_status_ff <= STATUS_RESET;
        end else begin
            temperature_status_ff <= STATUS_RESET;
            temperature_status_ff[TEMP_DIS_WARM_BIT] <= levels_in.discharge_too_warm;
            temperature_status_ff[TEMP_DIS_CHILLY_BIT] <= levels_in.discharge_too_chilly;
            temperature_status_ff[TEMP_CHG_WARM_BIT] <= levels_in.charge_too_warm;
            temperature_status_ff[TEMP_CHG_CHILLY_BIT] <= levels_in.charge_too_chilly;
        end
    end

    // ----------------------------------------
    // depletion qualification
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            depl_cnt_ff <= 32'h00000000;
            depleted_ff <= 1'b0;
        end else if (!levels_in.storage_at_depletion) begin
            // any rise above the limit restarts qualification
            depl_cnt_ff <= 32'h00000000;
            depleted_ff <= 1'b0;
        end else if (depl_cnt_ff >= 32'(QUALIFY_CYCLES)) begin
            // held longer than the qualification time
            depleted_ff <= 1'b1;
        end else begin
            depl_cnt_ff <= depl_cnt_ff + 32'h00000001;
        end
    end

    // ----------------------------------------
    // slot divider and window sequencing
    // ----------------------------------------
    assign slots_per_window = long_window_in ? 8'(SLOTS_LONG_WINDOW) : 8'(SLOTS_SHORT_WINDOW);
    assign window_end = slot_tick_ff && (slots_in_window_ff == slots_per_window - 8'h01);
    assign span_end = window_end && (windows_done_ff >= window_sum_setting_in);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slot_cnt_ff <= 32'h00000000;
            slot_tick_ff <= 1'b0;
        end else if (slot_cnt_ff >= 32'(SLOT_CYCLES - 1)) begin
            // one-cycle slot enable
            slot_cnt_ff <= 32'h00000000;
            slot_tick_ff <= 1'b1;
        end else begin
            slot_cnt_ff <= slot_cnt_ff + 32'h00000001;
            slot_tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slots_in_window_ff <= 8'h00;
            windows_done_ff <= '0;
        end else if (slot_tick_ff) begin
            if (window_end || slots_in_window_ff >= slots_per_window) begin
                // window closes; count it toward the summed span
                slots_in_window_ff <= 8'h00;
                windows_done_ff <= span_end ? '0 : windows_done_ff + SETTING_W'(1);
            end else begin
                slots_in_window_ff <= slots_in_window_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // per-converter accumulation and latching
    // ----------------------------------------
    for (genvar c = 0; c < CONVERTER_N; c++) begin : g_conv
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                acc_ff[c] <= '0;
                meter_ff[c] <= METER_RESET;
            end else begin
                if (span_end) begin
                    // publish the whole summed span, plain count only for a single pulse counter window
                    meter_ff[c] <= encode(acc_ff[c], (mode_in == SEM_PULSE_COUNTER) &&
                                          (window_sum_setting_in == '0));
                    acc_ff[c] <= '0;
                end else if (conv_in[c].pulse && !(&acc_ff[c])) begin
                    if (mode_in == SEM_PULSE_COUNTER) begin
                        // one per drawn pulse
                        acc_ff[c] <= acc_ff[c] + ACC_W'(1);
                    end else begin
                        // weighted by the pulse energy
                        acc_ff[c] <= acc_ff[c] + ACC_W'(conv_in[c].energy);
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // charger duty counter
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            duty_acc_ff <= '0;
            duty_ff <= DUTY_RESET;
        end else if (span_end) begin
            // saturate at 16 bits
            duty_ff <= duty_acc_ff[DUTY_W] ? {DUTY_W{1'b1}} : duty_acc_ff[DUTY_W-1:0];
            duty_acc_ff <= '0;
        end else if (slot_tick_ff && aux_charging_in && !duty_acc_ff[DUTY_W]) begin
            // one count per slot spent charging
            duty_acc_ff <= duty_acc_ff + (DUTY_W+1)'(1);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            window_done_ff <= 1'b0;
        end else begin
            window_done_ff <= span_end;
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always_comb begin
        case (rd_addr_in)
            ADDR_CORE_STATUS: nxt_rd_data = core_status_ff;
            ADDR_TEMPERATURE_STATUS: nxt_rd_data = temperature_status_ff;
            ADDR_SRC1_METER_LOW: nxt_rd_data = meter_ff[0][7:0];
            ADDR_SRC1_METER_MID: nxt_rd_data = meter_ff[0][15:8];
            ADDR_SRC1_METER_HIGH: nxt_rd_data = meter_ff[0][23:16];
            ADDR_SRC2_METER_LOW: nxt_rd_data = meter_ff[1][7:0];
            ADDR_SRC2_METER_MID: nxt_rd_data = meter_ff[1][15:8];
            ADDR_SRC2_METER_HIGH: nxt_rd_data = meter_ff[1][23:16];
            ADDR_OUTPUT_METER_LOW: nxt_rd_data = meter_ff[2][7:0];
            ADDR_OUTPUT_METER_MID: nxt_rd_data = meter_ff[2][15:8];
            ADDR_OUTPUT_METER_HIGH: nxt_rd_data = meter_ff[2][23:16];
            ADDR_CHARGER_DUTY_LOW: nxt_rd_data = duty_ff[7:0];
            ADDR_CHARGER_DUTY_HIGH: nxt_rd_data = duty_ff[15:8];
            default: nxt_rd_data = UNMAPPED_READ;
        endcase
    end

    // reads only sample; nothing changes state
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
            if (rd_en_in) begin
                rd_data_out <= nxt_rd_data;
            end
        end
    end

    assign window_done_out = window_done_ff;

endmodule : sem_meter_readout

// ===== test/sem_meter_readout_monitor.sv
`timescale 1ns/1ps
module sem_meter_readout_monitor
    import sem_pkg::*;
#(
    parameter int SETTING_W = 3, // setting width
    parameter int SLOT_CYCLES = 4, // clocks per slot
    parameter int QUALIFY_CYCLES = 5, // depletion hold
    parameter int ACC_W = 40 // accumulator width
) (
    input wire logic clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire sem_pkg::sem_levels_t levels_in, // levels
    input wire sem_pkg::sem_pulse_t [sem_pkg::CONVERTER_N-1:0] conv_in, // pulses
    input wire logic aux_charging_in, // charging
    input wire sem_pkg::sem_mode_t mode_in, // mode
    input wire logic long_window_in, // window
    input wire logic [SETTING_W-1:0] window_sum_setting_in, // setting
    input wire logic rd_en_in, // read strobe
    input wire logic [7:0] rd_addr_in, // offset
    input wire logic [7:0] rd_data_out, // read byte
    input wire logic rd_valid_out, // read valid
    input wire logic window_done_out // span done
);
    // ------------
    // depletion hold count
    // ------------
    logic [15:0] held_ff; // cycles the depletion level stayed high
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            held_ff <= 16'h0000;
        end else if (!levels_in.storage_at_depletion) begin
            held_ff <= 16'h0000; // level dropped
        end else if (held_ff != 16'hffff) begin
            held_ff <= held_ff + 16'h0001; // saturating count
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // read requests by kind
    sequence core_rd;
        rd_en_in && rd_addr_in == ADDR_CORE_STATUS;
    endsequence
    sequence temp_rd;
        rd_en_in && rd_addr_in == ADDR_TEMPERATURE_STATUS;
    endsequence
    sequence spare_rd;
        rd_en_in && (rd_addr_in < ADDR_CORE_STATUS || rd_addr_in > ADDR_CHARGER_DUTY_HIGH);
    endsequence
    read_answer_a: assert property (rd_en_in |=> rd_valid_out)
        else $error("read not answered");
    stray_valid_a: assert property (!rd_en_in |=> !rd_valid_out)
        else $error("valid without read");
    core_bits_a: assert property (core_rd |=> rd_data_out[5:1] == $past(levels_in[9:5], 2))
        else $error("core status bits wrong");
    core_spare_a: assert property (core_rd |=> rd_data_out[7:6] == 2'b00)
        else $error("core spare bits set");
    temp_bits_a: assert property (temp_rd |=> rd_data_out == {4'h0, $past(levels_in[3:0], 2)})
        else $error("temperature status wrong");
    unmapped_zero_a: assert property (spare_rd |=> rd_data_out == UNMAPPED_READ)
        else $error("unmapped read not zero");
    depleted_early_a: assert property (core_rd ##0 (held_ff < QUALIFY_CYCLES) |=> !rd_data_out[0])
        else $error("depletion flag too early");
    depleted_late_a: assert property (core_rd ##0 (held_ff > QUALIFY_CYCLES + 3) |=> rd_data_out[0])
        else $error("depletion flag missing");
    depleted_clear_a: assert property (core_rd ##0 (!$past(levels_in[4], 2) && !$past(levels_in[4], 3))
        |=> !rd_data_out[0])
        else $error("depletion flag stuck");
    done_pulse_a: assert property (window_done_out |=> !window_done_out)
        else $error("span done longer than one cycle");
endmodule : sem_meter_readout_monitor

bind sem_meter_readout sem_meter_readout_monitor #(.SETTING_W(SETTING_W), .SLOT_CYCLES(SLOT_CYCLES),
    .QUALIFY_CYCLES(QUALIFY_CYCLES), .ACC_W(ACC_W)) sem_meter_readout_monitor_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .levels_in(levels_in), .conv_in(conv_in),
    .aux_charging_in(aux_charging_in), .mode_in(mode_in), .long_window_in(long_window_in),
    .window_sum_setting_in(window_sum_setting_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .window_done_out(window_done_out));

// ===== test/sem_host_model.sv
`timescale 1ns/1ps
module sem_host_model (
    input wire logic clk_in, // bus clock
    input wire logic [7:0] rd_data_in, // byte from the device
    input wire logic rd_valid_in, // answer strobe
    output logic rd_en_out, // read strobe
    output logic [7:0] rd_addr_out // register offset
);
    // ------------
    // register reads
    // ------------
    initial begin
        rd_en_out = 1'b0;
        rd_addr_out = 8'h00;
    end
    // one read: strobe for one edge, then take the byte with the valid pulse
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        rd_en_out <= 1'b1;
        rd_addr_out <= addr;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        rd_addr_out <= ~addr; // released offset shows no stale value
        @(posedge clk_in);
        repeat (3) if (rd_valid_in !== 1'b1) @(posedge clk_in);
        data = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx; // no answer reads unknown
    endtask : read_reg
    // whole metering word: three bytes back to back within one span
    task automatic read_word(input logic [7:0] base, output logic [23:0] word);
        logic [7:0] lo;
        logic [7:0] mid;
        logic [7:0] hi;
        read_reg(base, lo);
        read_reg(base + 8'h01, mid);
        read_reg(base + 8'h02, hi);
        word = {hi, mid, lo};
    endtask : read_word
endmodule : sem_host_model

// ===== test/sem_meter_readout_test.sv
`timescale 1ns/1ps
module sem_meter_readout_test;
    import sem_pkg::*;
    localparam int SLOT = 4; // short slot
    localparam int QUAL = 5; // short depletion hold
    logic clk_in; // clock
    logic sys_rst_in; // reset
    sem_levels_t levels_in; // levels
    sem_pulse_t [CONVERTER_N-1:0] conv_in; // pulses
    logic aux_charging_in; // charging
    sem_mode_t mode_in; // mode
    logic long_window_in; // window
    logic [2:0] window_sum_setting_in; // setting
    logic rd_en_in; // read strobe
    logic [7:0] rd_addr_in; // offset
    logic [7:0] rd_data_out; // read byte
    logic rd_valid_out; // read valid
    logic window_done_out; // span done
    int error_cnt = 0; // mismatches
    int checks = 0; // comparisons
    int seed = 32'h7354; // random seed
    logic [7:0] b; // last byte read
    sem_levels_t lv; // drawn levels
    sem_meter_readout #(.SETTING_W(3), .SLOT_CYCLES(SLOT), .QUALIFY_CYCLES(QUAL), .ACC_W(40))
    sem_meter_readout_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .levels_in(levels_in),
        .conv_in(conv_in), .aux_charging_in(aux_charging_in), .mode_in(mode_in),
        .long_window_in(long_window_in), .window_sum_setting_in(window_sum_setting_in),
        .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .window_done_out(window_done_out));
    sem_host_model sem_host_model_inst (.clk_in(clk_in), .rd_data_in(rd_data_out),
        .rd_valid_in(rd_valid_out), .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in));
    // ------------
    // helpers
    // ------------
    task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %0t %s: %h, expected %h", $time, what, seen, want);
        end
    endtask : check
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic rd(input logic [7:0] a);
        sem_host_model_inst.read_reg(a, b);
    endtask : rd
    // expected status byte from the levels
    function automatic logic [23:0] stat_exp(input sem_levels_t l, input logic core);
        if (core) return {18'h0, l[9:5], 1'b0};
        return {20'h0, l[3:0]};
    endfunction : stat_exp
    // expected metering word: plain count or exponent and mantissa
    function automatic logic [23:0] enc(input logic [39:0] raw, input logic plain);
        int e;
        if (plain) return (raw > 40'h7fffff) ? 24'h7fffff : {1'b0, raw[22:0]};
        e = 0;
        while ((raw >> e) >= 40'h80000) e++;
        return {5'(e), 19'(raw >> e)};
    endfunction : enc
    task automatic wait_done();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (window_done_out !== 1'b1 && k < 5000);
        // a span end that never comes is a failure, not a silent return
        if (window_done_out !== 1'b1) error_cnt++;
    endtask : wait_done
    // one full span under a fresh setting, then all words read back
    task automatic run_span(input sem_mode_t m, input logic lw, input logic [2:0] s,
        input logic [7:0] en, input logic ax, input logic big);
        int n[3];
        int len;
        int gap;
        logic [23:0] w;
        len = SLOT * (lw ? SLOTS_LONG_WINDOW : SLOTS_SHORT_WINDOW) * (int'(s) + 1);
        mode_in <= m;
        long_window_in <= lw;
        window_sum_setting_in <= s;
        aux_charging_in <= ax;
        wait_done();
        wait_done();
        foreach (n[i]) n[i] = big ? len - 40 : {$random(seed)} % (len - 40);
        gap = 0;
        do begin
            foreach (n[i]) conv_in[i] <= '{pulse: (gap < n[i]), energy: en};
            @(posedge clk_in);
            gap++;
        end while (window_done_out !== 1'b1 && gap < len + 8);
        conv_in <= '0;
        check(24'(gap), 24'(len), "span length");
        for (int i = 0; i < 3; i++) begin
            sem_host_model_inst.read_word(ADDR_SRC1_METER_LOW + 8'(3 * i), w);
            check(w, enc(40'(n[i]) * (m == SEM_POWER_METER ? 40'(en) : 40'h1),
                m == SEM_PULSE_COUNTER && s == 3'h0), "meter word");
        end
        rd(ADDR_CHARGER_DUTY_LOW);
        w[7:0] = b;
        rd(ADDR_CHARGER_DUTY_HIGH);
        // charging the whole span reads the span's slot count minus one (the slot that ends the span is not counted)
        check({8'h0, b, w[7:0]}, ax ? 24'(len / SLOT - 1) : 24'h0, "charger duty");
    endtask : run_span
    // ------------
    // clock, watchdog and main sequence
    // ------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #6_000_000;
        error_cnt++;
        complete_run();
    end
    initial begin
        sys_rst_in = 1'b1;
        levels_in = '0;
        conv_in = '0;
        aux_charging_in = 1'b0;
        mode_in = SEM_PULSE_COUNTER;
        long_window_in = 1'b0;
        window_sum_setting_in = 3'h0;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int a = 8'h1a; a <= 8'h27; a++) begin
            rd(8'(a));
            check(24'(b), 24'h0, "reset value");
        end
        repeat (12) begin
            lv = sem_levels_t'(10'($random(seed)));
            lv.storage_at_depletion = 1'b0;
            levels_in <= lv;
            repeat (2) @(posedge clk_in);
            rd(ADDR_CORE_STATUS);
            check(24'(b), stat_exp(lv, 1'b1), "core status");
            rd(ADDR_CORE_STATUS);
            check(24'(b), stat_exp(lv, 1'b1), "core reread");
            rd(ADDR_TEMPERATURE_STATUS);
            check(24'(b), stat_exp(lv, 1'b0), "temperature status");
        end
        levels_in <= '0;
        @(posedge clk_in);
        levels_in.storage_at_depletion <= 1'b1;
        repeat (QUAL - 3) @(posedge clk_in);
        rd(ADDR_CORE_STATUS);
        check(24'(b[0]), 24'h0, "depletion early");
        repeat (QUAL + 4) @(posedge clk_in);
        rd(ADDR_CORE_STATUS);
        check(24'(b[0]), 24'h1, "depletion held");
        levels_in.storage_at_depletion <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd(ADDR_CORE_STATUS);
        check(24'(b[0]), 24'h0, "depletion cleared");
        run_span(SEM_PULSE_COUNTER, 1'b0, 3'h0, 8'h01, 1'b1, 1'b0);
        run_span(SEM_PULSE_COUNTER, 1'b1, 3'h2, 8'h01, 1'b0, 1'b0);
        run_span(SEM_POWER_METER, 1'b1, 3'h7, 8'hff, 1'b1, 1'b1);
        run_span(SEM_POWER_METER, 1'b0, 3'h1, 8'($random(seed)), 1'b1, 1'b0);
        rd(8'hff);
        check(24'(b), 24'h0, "unmapped read");
        complete_run();
    end
endmodule : sem_meter_readout_test
